// ==== rtl/driver_ctrl_pkg.sv ====
// Constants for the high-side source and supply/bridge control registers.
// Assumes a core register port delivering decoded 24-bit reads and writes.
// Summary of operation
// - Five 4-bit source fields, bits 15:12 reserved
// - Codes: off, on, timers, PWM one-ten
// - Codes 1110/1111 follow direction outputs one/two
// - Lockout enables reset 1, hold outputs off
// - Lockout clear: auto restart, auto flag clear
// - Standby modes always disable lockout
// - Bit 21 gates buffered overvoltage shutdown
// - Bit 20 gates buffered undervoltage shutdown
// - Regulator undervolt with a supply undervolt forces fail-safe, outputs off
// - Bit 19: battery overvoltage shutdown, else pump-low
// - Bit 18 gates battery undervoltage shutdown
// - Bridge six threshold: 00/11 third level
// - Bridge five threshold, same mapping, 13:12 reserved
// - Bits 11:6 drive bridge switches directly
// - Never both switches of one bridge
// - Same sixteen-code encoding everywhere, off default
package driver_ctrl_pkg;
  localparam int          ADDR_W          = 7;
  localparam int          DATA_W          = 24;
  localparam logic [6:0]  SOURCE_SEL_ADDR = 7'h3C;
  localparam logic [6:0]  SUPPLY_CTL_ADDR = 7'h3D;
  localparam logic [23:0] SOURCE_SEL_RST  = 24'h000000;
  localparam logic [23:0] SUPPLY_CTL_RST  = 24'hFC0000;
  localparam logic [23:0] SOURCE_SEL_MASK = 24'hFF0FFF;
  localparam logic [23:0] SUPPLY_CTL_MASK = 24'hFFCFC0;
  // Source field low bit positions
  localparam int POS_TWELVE = 20;
  localparam int POS_ELEVEN = 16;
  localparam int POS_NINE   = 8;
  localparam int POS_EIGHT  = 4;
  localparam int POS_SEVEN  = 0;
  // Supply and bridge control bit positions
  localparam int POS_BUF_LOCK  = 23;
  localparam int POS_BAT_LOCK  = 22;
  localparam int POS_BUF_OV_SD = 21;
  localparam int POS_BUF_UV_SD = 20;
  localparam int POS_BAT_OV_SD = 19;
  localparam int POS_BAT_UV_SD = 18;
  localparam int POS_B6_OC     = 16;
  localparam int POS_B5_OC     = 14;
  localparam int POS_B6_UPPER  = 11;
  localparam int POS_B6_LOWER  = 10;
  localparam int POS_B5_UPPER  = 9;
  localparam int POS_B5_LOWER  = 8;
  localparam int POS_B4_UPPER  = 7;
  localparam int POS_B4_LOWER  = 6;
  // Source select codes
  localparam logic [3:0] SRC_OFF       = 4'h0;
  localparam logic [3:0] SRC_ON        = 4'h1;
  localparam logic [3:0] SRC_TIMER_ONE = 4'h2;
  localparam logic [3:0] SRC_TIMER_TWO = 4'h3;
  localparam logic [3:0] SRC_PWM_FIRST = 4'h4;
  localparam logic [3:0] SRC_PWM_LAST  = 4'hD;
  localparam logic [3:0] SRC_DIR_ONE   = 4'hE;
  localparam logic [3:0] SRC_DIR_TWO   = 4'hF;
  // Overcurrent level indices
  localparam logic [1:0] OC_LEVEL_ONE   = 2'h1;
  localparam logic [1:0] OC_LEVEL_TWO   = 2'h2;
  localparam logic [1:0] OC_LEVEL_THREE = 2'h3;
  // Order of the synchronised analogue inputs
  localparam int SYN_BUF_OV   = 0;
  localparam int SYN_BUF_UV   = 1;
  localparam int SYN_BAT_OV   = 2;
  localparam int SYN_BAT_UV   = 3;
  localparam int SYN_PUMP_LOW = 4;
  localparam int SYN_REG_UV   = 5;
  localparam int SYN_STANDBY  = 6;
  localparam int SYN_W        = 7;
endpackage

// ==== rtl/output_driver_control_regs.sv ====
// Source selection, supply protection and half-bridge control registers.
// Assumes a core that decodes serial frames into single-cycle register
// strobes, and timer, PWM and direction levels from logic on ref_clk.
`timescale 1ns/100ps
module output_driver_control_regs
  import driver_ctrl_pkg::*;
#(
  parameter int PWM_CHANNELS = 10
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire logic                    reg_write,
  input  wire logic                    reg_read,
  input  wire logic [ADDR_W-1:0]       reg_addr,
  input  wire logic [DATA_W-1:0]       reg_wdata,
  output logic      [DATA_W-1:0]       reg_rdata,
  output logic                         reg_rvalid,
  input  wire logic [1:0]              timer_level,
  input  wire logic [PWM_CHANNELS-1:0] pwm_level,
  input  wire logic                    direction_out_one,
  input  wire logic                    direction_out_two,
  input  wire logic [3:0]              fault_flag_clear,
  input  wire logic                    buffered_overvolt_cmp,
  input  wire logic                    buffered_undervolt_cmp,
  input  wire logic                    battery_overvolt_cmp,
  input  wire logic                    battery_undervolt_cmp,
  input  wire logic                    pump_low_threshold,
  input  wire logic                    main_regulator_undervolt,
  input  wire logic                    standby_mode,
  output logic                         high_side_twelve,
  output logic                         high_side_eleven,
  output logic                         high_side_nine,
  output logic                         high_side_eight,
  output logic                         high_side_seven,
  output logic                         bridge_six_upper_on,
  output logic                         bridge_six_lower_on,
  output logic                         bridge_five_upper_on,
  output logic                         bridge_five_lower_on,
  output logic                         bridge_four_upper_on,
  output logic                         bridge_four_lower_on,
  output logic [1:0]                   bridge_six_overcurrent_level,
  output logic [1:0]                   bridge_five_overcurrent_level,
  output logic                         buffered_outputs_enable,
  output logic                         buffered_overvolt_flag,
  output logic                         buffered_undervolt_flag,
  output logic                         battery_overvolt_flag,
  output logic                         battery_undervolt_flag,
  output logic                         fail_safe_mode
);

  logic [DATA_W-1:0] high_side_source_select_a;
  logic [DATA_W-1:0] supply_protect_bridge_ctrl;
  logic [SYN_W-1:0]  cmp_meta;
  logic [SYN_W-1:0]  cmp_sync;
  logic              buf_locked;
  logic              bat_locked;
  logic              buf_shutdown;
  logic              bat_shutdown;
  logic              buf_lock_eff;
  logic              bat_lock_eff;
  logic              fail_now;
  logic              buf_off;
  logic              bat_off;
  logic              next_buf_ov;
  logic              next_buf_uv;
  logic              next_bat_ov;
  logic              next_bat_uv;

  // Level picked by one 4-bit source field
  function automatic logic source_level(input logic [3:0] code,
                                        input logic [1:0] timers,
                                        input logic [PWM_CHANNELS-1:0] pwm,
                                        input logic dir_one,
                                        input logic dir_two);
    logic [3:0] idx;
    idx = code - SRC_PWM_FIRST;
    case (code)
      SRC_OFF:       source_level = 1'b0;
      SRC_ON:        source_level = 1'b1;
      SRC_TIMER_ONE: source_level = timers[0];
      SRC_TIMER_TWO: source_level = timers[1];
      SRC_DIR_ONE:   source_level = dir_one;
      SRC_DIR_TWO:   source_level = dir_two;
      default: begin
        // PWM one to ten in code order; absent channels read low
        if (code <= SRC_PWM_LAST && int'(idx) < PWM_CHANNELS) begin
          source_level = pwm[idx];
        end else begin
          source_level = 1'b0;
        end
      end
    endcase
  endfunction

  // Map threshold code to level; 00 and 11 both mean the third level
  function automatic logic [1:0] oc_level(input logic [1:0] code);
    case (code)
      2'h1:    oc_level = OC_LEVEL_ONE;
      2'h2:    oc_level = OC_LEVEL_TWO;
      default: oc_level = OC_LEVEL_THREE;
    endcase
  endfunction

  // Comparator and mode levels come from the analogue side: two flops
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmp_meta <= '0;
      cmp_sync <= '0;
    end else begin
      cmp_meta <= {standby_mode, main_regulator_undervolt, pump_low_threshold,
                   battery_undervolt_cmp, battery_overvolt_cmp,
                   buffered_undervolt_cmp, buffered_overvolt_cmp};
      cmp_sync <= cmp_meta;
    end
  end

  // Source select register; reserved nibble never stored
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      high_side_source_select_a <= SOURCE_SEL_RST;
    end else if (reg_write && reg_addr == SOURCE_SEL_ADDR) begin
      high_side_source_select_a <= reg_wdata & SOURCE_SEL_MASK;
    end
  end

  // Supply and bridge register; interlock never rewrites it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      supply_protect_bridge_ctrl <= SUPPLY_CTL_RST;
    end else if (reg_write && reg_addr == SUPPLY_CTL_ADDR) begin
      supply_protect_bridge_ctrl <= reg_wdata & SUPPLY_CTL_MASK;
    end
  end

  // Readback, one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (!reg_read) begin
        reg_rdata <= '0;
      end else if (reg_addr == SOURCE_SEL_ADDR) begin
        reg_rdata <= high_side_source_select_a;
      end else if (reg_addr == SUPPLY_CTL_ADDR) begin
        reg_rdata <= supply_protect_bridge_ctrl;
      end else begin
        reg_rdata <= '0;
      end
    end
  end

  // Shutdown requests per supply; standby wipes out lockout
  always_comb begin
    buf_lock_eff = supply_protect_bridge_ctrl[POS_BUF_LOCK] & ~cmp_sync[SYN_STANDBY];
    bat_lock_eff = supply_protect_bridge_ctrl[POS_BAT_LOCK] & ~cmp_sync[SYN_STANDBY];
    buf_shutdown = (cmp_sync[SYN_BUF_OV] & supply_protect_bridge_ctrl[POS_BUF_OV_SD])
                 | (cmp_sync[SYN_BUF_UV] & supply_protect_bridge_ctrl[POS_BUF_UV_SD]);
    // With shutdown disabled the pump-low level still protects the outputs
    bat_shutdown = (cmp_sync[SYN_BAT_OV] & (supply_protect_bridge_ctrl[POS_BAT_OV_SD]
                                            | cmp_sync[SYN_PUMP_LOW]))
                 | (cmp_sync[SYN_BAT_UV] & supply_protect_bridge_ctrl[POS_BAT_UV_SD]);
    fail_now     = cmp_sync[SYN_REG_UV] & (cmp_sync[SYN_BUF_UV] | cmp_sync[SYN_BAT_UV]);
  end

  // Fault flags: set wins over clear; auto-clear once fault ends unlocked
  always_comb begin
    next_buf_ov = buffered_overvolt_flag;
    next_buf_uv = buffered_undervolt_flag;
    next_bat_ov = battery_overvolt_flag;
    next_bat_uv = battery_undervolt_flag;
    if (fault_flag_clear[0]) next_buf_ov = 1'b0;
    if (fault_flag_clear[1]) next_buf_uv = 1'b0;
    if (fault_flag_clear[2]) next_bat_ov = 1'b0;
    if (fault_flag_clear[3]) next_bat_uv = 1'b0;
    if (!buf_lock_eff && !cmp_sync[SYN_BUF_OV] && !cmp_sync[SYN_BUF_UV]) begin
      next_buf_ov = 1'b0;
      next_buf_uv = 1'b0;
    end
    if (!bat_lock_eff && !cmp_sync[SYN_BAT_OV] && !cmp_sync[SYN_BAT_UV]) begin
      next_bat_ov = 1'b0;
      next_bat_uv = 1'b0;
    end
    if (cmp_sync[SYN_BUF_OV]) next_buf_ov = 1'b1;
    if (cmp_sync[SYN_BUF_UV]) next_buf_uv = 1'b1;
    if (cmp_sync[SYN_BAT_OV]) next_bat_ov = 1'b1;
    if (cmp_sync[SYN_BAT_UV]) next_bat_uv = 1'b1;
  end

  // Flag registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      buffered_overvolt_flag  <= 1'b0;
      buffered_undervolt_flag <= 1'b0;
      battery_overvolt_flag   <= 1'b0;
      battery_undervolt_flag  <= 1'b0;
    end else begin
      buffered_overvolt_flag  <= next_buf_ov;
      buffered_undervolt_flag <= next_buf_uv;
      battery_overvolt_flag   <= next_bat_ov;
      battery_undervolt_flag  <= next_bat_uv;
    end
  end

  // Lockout latches: held until both flags of the supply are gone or lockout is disabled
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      buf_locked <= 1'b0;
      bat_locked <= 1'b0;
    end else begin
      if (buf_shutdown && buf_lock_eff) begin
        buf_locked <= 1'b1;
      end else if (!buf_lock_eff || (!buffered_overvolt_flag && !buffered_undervolt_flag)) begin
        buf_locked <= 1'b0;
      end
      if (bat_shutdown && bat_lock_eff) begin
        bat_locked <= 1'b1;
      end else if (!bat_lock_eff || (!battery_overvolt_flag && !battery_undervolt_flag)) begin
        bat_locked <= 1'b0;
      end
    end
  end

  // Combined off conditions per supply
  assign buf_off = buf_shutdown | buf_locked | fail_now;
  assign bat_off = bat_shutdown | bat_locked | fail_now;

  // Fail-safe indication and buffered-supply enable for the outer drivers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fail_safe_mode          <= 1'b0;
      buffered_outputs_enable <= 1'b0;
    end else begin
      fail_safe_mode          <= fail_now;
      buffered_outputs_enable <= ~buf_off;
    end
  end

  // High-side drivers sit on the battery supply and follow their source
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      high_side_twelve <= 1'b0;
      high_side_eleven <= 1'b0;
      high_side_nine   <= 1'b0;
      high_side_eight  <= 1'b0;
      high_side_seven  <= 1'b0;
    end else begin
      high_side_twelve <= ~bat_off & source_level(high_side_source_select_a[POS_TWELVE+:4],
                          timer_level, pwm_level, direction_out_one, direction_out_two);
      high_side_eleven <= ~bat_off & source_level(high_side_source_select_a[POS_ELEVEN+:4],
                          timer_level, pwm_level, direction_out_one, direction_out_two);
      high_side_nine   <= ~bat_off & source_level(high_side_source_select_a[POS_NINE+:4],
                          timer_level, pwm_level, direction_out_one, direction_out_two);
      high_side_eight  <= ~bat_off & source_level(high_side_source_select_a[POS_EIGHT+:4],
                          timer_level, pwm_level, direction_out_one, direction_out_two);
      high_side_seven  <= ~bat_off & source_level(high_side_source_select_a[POS_SEVEN+:4],
                          timer_level, pwm_level, direction_out_one, direction_out_two);
    end
  end

  // Bridges: a conflicting pair turns both switches off, never both on
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bridge_six_upper_on  <= 1'b0;
      bridge_six_lower_on  <= 1'b0;
      bridge_five_upper_on <= 1'b0;
      bridge_five_lower_on <= 1'b0;
      bridge_four_upper_on <= 1'b0;
      bridge_four_lower_on <= 1'b0;
    end else begin
      bridge_six_upper_on  <= ~bat_off & supply_protect_bridge_ctrl[POS_B6_UPPER]
                              & ~supply_protect_bridge_ctrl[POS_B6_LOWER];
      bridge_six_lower_on  <= ~bat_off & supply_protect_bridge_ctrl[POS_B6_LOWER]
                              & ~supply_protect_bridge_ctrl[POS_B6_UPPER];
      bridge_five_upper_on <= ~bat_off & supply_protect_bridge_ctrl[POS_B5_UPPER]
                              & ~supply_protect_bridge_ctrl[POS_B5_LOWER];
      bridge_five_lower_on <= ~bat_off & supply_protect_bridge_ctrl[POS_B5_LOWER]
                              & ~supply_protect_bridge_ctrl[POS_B5_UPPER];
      bridge_four_upper_on <= ~bat_off & supply_protect_bridge_ctrl[POS_B4_UPPER]
                              & ~supply_protect_bridge_ctrl[POS_B4_LOWER];
      bridge_four_lower_on <= ~bat_off & supply_protect_bridge_ctrl[POS_B4_LOWER]
                              & ~supply_protect_bridge_ctrl[POS_B4_UPPER];
    end
  end

  // Overcurrent levels for the comparators, registered
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bridge_six_overcurrent_level  <= OC_LEVEL_THREE;
      bridge_five_overcurrent_level <= OC_LEVEL_THREE;
    end else begin
      bridge_six_overcurrent_level  <= oc_level(supply_protect_bridge_ctrl[POS_B6_OC+:2]);
      bridge_five_overcurrent_level <= oc_level(supply_protect_bridge_ctrl[POS_B5_OC+:2]);
    end
  end

endmodule

// ==== testbench/output_driver_control_regs_monitor.sv ====
// Checker on the driver control register ports.
// Assumes a bind onto output_driver_control_regs, one clock domain.
`timescale 1ns/100ps
module output_driver_control_regs_monitor
  import driver_ctrl_pkg::*;
(
  input logic              ref_clk,
  input logic              reset,
  input logic              reg_write,
  input logic              reg_read,
  input logic [ADDR_W-1:0] reg_addr,
  input logic [DATA_W-1:0] reg_wdata,
  input logic [DATA_W-1:0] reg_rdata,
  input logic              reg_rvalid,
  input logic              battery_undervolt_cmp,
  input logic              main_regulator_undervolt,
  input logic              high_side_seven,
  input logic              bridge_six_upper_on,
  input logic              bridge_six_lower_on,
  input logic              bridge_five_upper_on,
  input logic              bridge_five_lower_on,
  input logic              bridge_four_upper_on,
  input logic              bridge_four_lower_on,
  input logic [1:0]        bridge_six_overcurrent_level,
  input logic [1:0]        bridge_five_overcurrent_level,
  input logic              fail_safe_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Read port timing and values
  property p_read_answer;
    reg_read |=> reg_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_idle;
    !reg_read |=> !reg_rvalid && reg_rdata == 24'h000000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data without a read");
  property p_write_read;
    reg_write && reg_addr == SOURCE_SEL_ADDR ##1 reg_read && reg_addr == SOURCE_SEL_ADDR
      |=> reg_rdata == ($past(reg_wdata, 2) & 24'hFF0FFF);
  endproperty
  a_write_read: assert property (p_write_read) else $error("source word not read back");
  property p_reserved;
    reg_read && reg_addr == SOURCE_SEL_ADDR |=> reg_rdata[15:12] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");
  // Bridge interlock, never both switches of one leg
  property p_interlock;
    !(bridge_six_upper_on && bridge_six_lower_on) && !(bridge_five_upper_on && bridge_five_lower_on)
      && !(bridge_four_upper_on && bridge_four_lower_on);
  endproperty
  a_interlock: assert property (p_interlock) else $error("cross current on a bridge");
  property p_interlock_off;
    reg_write && reg_addr == SUPPLY_CTL_ADDR && reg_wdata[11:10] == 2'h3
      |=> ##1 !bridge_six_upper_on && !bridge_six_lower_on;
  endproperty
  a_interlock_off: assert property (p_interlock_off) else $error("bridge six not held off");
  property p_level;
    bridge_six_overcurrent_level != 2'h0 && bridge_five_overcurrent_level != 2'h0;
  endproperty
  a_level: assert property (p_level) else $error("overcurrent level index zero");
  // Synchroniser latency is three edges, four cycles leaves margin
  property p_fail_safe;
    (main_regulator_undervolt && battery_undervolt_cmp) [*4] |=> fail_safe_mode && !high_side_seven;
  endproperty
  a_fail_safe: assert property (p_fail_safe) else $error("fail safe not entered");
endmodule

// ==== testbench/host_register_model.sv ====
// Host controller model issuing register strobes.
// Assumes one-cycle strobes taken on the rising ref_clk edge.
`timescale 1ns/100ps
module host_register_model
  import driver_ctrl_pkg::*;
(
  input  wire logic              ref_clk,
  output logic                   reg_write,
  output logic                   reg_read,
  output logic [ADDR_W-1:0]      reg_addr,
  output logic [DATA_W-1:0]      reg_wdata,
  input  wire logic [DATA_W-1:0] reg_rdata,
  input  wire logic              reg_rvalid
);
  logic [ADDR_W-1:0] addr_q = 7'h55;
  logic [DATA_W-1:0] data_q = 24'hA5A5A5;
  // Time of the last strobe release, so back-to-back calls let an edge pass
  time               wr_end = 0;
  time               rd_end = 0;
  // Idle bus inverted, so a stale word never looks valid
  assign reg_addr  = (reg_write || reg_read) ? addr_q : ~addr_q;
  assign reg_wdata = reg_write ? data_q : ~data_q;
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    if ($time == wr_end) begin
      @(posedge ref_clk);
      #1;
    end
    addr_q = a;
    data_q = d;
    reg_write = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_write = 1'b0;
    wr_end = $time;
  endtask
  // Answer stands from the edge that takes the strobe, read 1 ns later
  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    if ($time == rd_end) begin
      @(posedge ref_clk);
      #1;
    end
    addr_q = a;
    reg_read = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_read = 1'b0;
    d = reg_rvalid ? reg_rdata : 24'hXXXXXX;
    rd_end = $time;
  endtask
endmodule

// ==== testbench/test_output_driver_control_regs.sv ====
// Self-checking bench for the driver control registers.
// Assumes the host model and checker compile before this file.
`timescale 1ns/100ps
module test_output_driver_control_regs
  import driver_ctrl_pkg::*;
;
  logic        ref_clk, reset, reg_write, reg_read, reg_rvalid;
  logic [6:0]  reg_addr, cmp;
  logic [23:0] reg_wdata, reg_rdata, src_m, ctl_m, rd;
  logic [1:0]  timer_level, bridge_six_overcurrent_level, bridge_five_overcurrent_level;
  logic [9:0]  pwm_level;
  logic [3:0]  fault_flag_clear, k;
  logic        direction_out_one, direction_out_two, buffered_overvolt_cmp, buffered_undervolt_cmp;
  logic        battery_overvolt_cmp, battery_undervolt_cmp, pump_low_threshold, main_regulator_undervolt;
  logic        standby_mode, buffered_outputs_enable, fail_safe_mode;
  logic        high_side_twelve, high_side_eleven, high_side_nine, high_side_eight, high_side_seven;
  logic        bridge_six_upper_on, bridge_six_lower_on, bridge_five_upper_on, bridge_five_lower_on;
  logic        bridge_four_upper_on, bridge_four_lower_on, buffered_overvolt_flag, buffered_undervolt_flag;
  logic        battery_overvolt_flag, battery_undervolt_flag;
  int          n_errors = 0;
  int          total_checks = 0;
  wire  [4:0]  drv = {high_side_twelve, high_side_eleven, high_side_nine, high_side_eight, high_side_seven};
  wire  [5:0]  brg = {bridge_six_upper_on, bridge_six_lower_on, bridge_five_upper_on,
                      bridge_five_lower_on, bridge_four_upper_on, bridge_four_lower_on};
  wire  [3:0]  flags = {battery_undervolt_flag, battery_overvolt_flag, buffered_undervolt_flag,
                        buffered_overvolt_flag};
  assign {standby_mode, main_regulator_undervolt, pump_low_threshold, battery_undervolt_cmp,
          battery_overvolt_cmp, buffered_undervolt_cmp, buffered_overvolt_cmp} = cmp;
  output_driver_control_regs dut (.*);
  host_register_model host (.*);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic stop_test;
    $display("Checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Register model keeps only the implemented bits
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    host.write_reg(a, d);
    if (a == 7'h3C) src_m = d & 24'hFF0FFF;
    if (a == 7'h3D) ctl_m = d & 24'hFFCFC0;
  endtask
  task automatic rdchk(input logic [6:0] a);
    host.read_reg(a, rd);
    check("readback", rd, (a == 7'h3C) ? src_m : (a == 7'h3D) ? ctl_m : 24'h000000);
  endtask
  function automatic logic sel(input logic [3:0] c);
    case (c)
      4'h0: sel = 1'b0;
      4'h1: sel = 1'b1;
      4'h2, 4'h3: sel = timer_level[c - 4'h2];
      4'hE: sel = direction_out_one;
      4'hF: sel = direction_out_two;
      default: sel = pwm_level[c - 4'h4];
    endcase
  endfunction
  function automatic logic [1:0] pair(input logic [1:0] b);
    pair = (b == 2'h3) ? 2'h0 : b;
  endfunction
  function automatic logic [1:0] lv(input logic [1:0] x);
    lv = (x == 2'h0) ? 2'h3 : x;
  endfunction
  // One supply event: during, after release, after software clear
  task automatic fault(input logic [23:0] ctl, input logic [6:0] c, input logic [3:0] e);
    wr(7'h3D, ctl);
    cmp = c;
    step(6);
    check("during fault", {drv, buffered_outputs_enable}, {{5{e[3]}}, e[2]});
    cmp = c & 7'h40;
    step(6);
    check("after fault", {drv, buffered_outputs_enable}, {{5{e[1]}}, e[0]});
    cmp = 7'h00;
    fault_flag_clear = 4'hF;
    step(1);
    fault_flag_clear = 4'h0;
    step(6);
    check("recovered", {drv, buffered_outputs_enable, flags}, {6'h3F, 4'h0});
  endtask
  // Watchdog, far beyond the expected run of under a thousand cycles
  initial begin
    #1000000;
    n_errors++;
    stop_test;
  end
  initial begin
    reset = 1'b1;
    cmp = 7'h00;
    fault_flag_clear = 4'h0;
    {timer_level, pwm_level, direction_out_one, direction_out_two} = 14'h0000;
    src_m = 24'h000000;
    ctl_m = 24'hFC0000;
    void'($urandom(32'h75EB));
    step(8);
    reset = 1'b0;
    check("reset outputs", {drv, brg, bridge_six_overcurrent_level, bridge_five_overcurrent_level}, 15'h000F);
    rdchk(7'h3C);
    rdchk(7'h3D);
    for (int i = 0; i < 8; i++) begin
      wr(7'h3C, 24'($urandom));
      rdchk(7'h3C);
      wr(7'h40 + 7'(i), 24'($urandom));
      wr(7'h3D, 24'($urandom));
      rdchk(7'h3D);
      rdchk(7'h3E + 7'(i));
    end
    // Every code in every field, sources changing each cycle
    for (int c = 0; c < 16; c++) begin
      k = 4'(c);
      wr(7'h3C, {k, k + 4'h1, 4'h0, k + 4'h2, k + 4'h3, k + 4'h4});
      repeat (4) begin
        {timer_level, pwm_level, direction_out_one, direction_out_two} = 14'($urandom);
        step(1);
        check("drivers", drv, {sel(src_m[23:20]), sel(src_m[19:16]), sel(src_m[11:8]), sel(src_m[7:4]), sel(src_m[3:0])});
      end
    end
    // All switch pairs and threshold codes
    for (int i = 0; i < 64; i++) begin
      wr(7'h3D, {6'h3F, i[3:0], 2'h0, i[5:0], 6'h00});
      step(1);
      check("bridges", {brg, bridge_six_overcurrent_level, bridge_five_overcurrent_level}, {pair(i[5:4]), pair(i[3:2]), pair(i[1:0]), lv(i[3:2]), lv(i[1:0])});
      rdchk(7'h3D);
    end
    wr(7'h3C, 24'h110111);
    fault(24'hFC0000, 7'h04, 4'b0101);
    fault(24'hBC0000, 7'h04, 4'b0111);
    fault(24'hB40000, 7'h04, 4'b1111);
    fault(24'hB40000, 7'h14, 4'b0111);
    fault(24'hB80000, 7'h08, 4'b1111);
    fault(24'h380000, 7'h28, 4'b0011);
    fault(24'hFC0000, 7'h01, 4'b1010);
    fault(24'h5C0000, 7'h01, 4'b1111);
    fault(24'h7C0000, 7'h02, 4'b1011);
    fault(24'h6C0000, 7'h02, 4'b1111);
    fault(24'hFC0000, 7'h44, 4'b0111);
    step(2);
    stop_test;
  end
endmodule
bind output_driver_control_regs output_driver_control_regs_monitor mon (.*);
